// ---- rtl/vdc_consts.vh ----
// Constants for the two-channel video DMA addressing block.
// Included by the design files; holds definitions only.
`ifndef VDC_CONSTS_VH
`define VDC_CONSTS_VH
`define VDC_OFS_C1_ODD 6'h00
`define VDC_OFS_C1_EVEN 6'h04
`define VDC_OFS_C1_GUARD 6'h08
`define VDC_OFS_C1_STRIDE 6'h0c
`define VDC_OFS_C1_XLAT 6'h10
`define VDC_OFS_C1_SIZE 6'h14
`define VDC_OFS_C2_ODD 6'h18
`define VDC_OFS_C2_EVEN 6'h1c
`define VDC_OFS_C2_GUARD 6'h20
`define VDC_OFS_C2_STRIDE 6'h24
`define VDC_OFS_C2_XLAT 6'h28
`define VDC_REG_RESET 32'h0000_0000
`define VDC_GUARD_MASK 32'hffff_fffc
`define VDC_XLAT_MASK_C1 32'hffff_f8fb
`define VDC_XLAT_MASK_C2 32'hffff_f8ff
`define VDC_SIZE_MASK 32'h0fff_0fff
`define VDC_TBASE_HI 31
`define VDC_TBASE_LO 12
`define VDC_ME_BIT 11
`define VDC_LIM_HI 7
`define VDC_LIM_LO 4
`define VDC_PV_BIT 3
`define VDC_DIR_BIT 2
`define VDC_SWAP_HI 1
`define VDC_SWAP_LO 0
`define VDC_LINES_HI 27
`define VDC_LINES_LO 16
`define VDC_PIX_HI 11
`define VDC_PIX_LO 0
`define VDC_SWAP_NONE 2'h0
`define VDC_SWAP_HALF 2'h1
`define VDC_SWAP_FULL 2'h2
`define VDC_LIM_BASE 5'h0a
`endif

// ---- rtl/vdc_chan_addr.v ----
// One channel's line address generator, guard compare, range event and byte swap.
// Assumes a start pulse per field and a step pulse per line/dword from the mover.
`timescale 1ns/100ps
`include "vdc_consts.vh"
module vdc_chan_addr #(
   parameter AW = 32
) (
   input wire mclk,
   input wire reset_n,
   input wire field_start,
   input wire field_odd,
   input wire line_next,
   input wire [AW-1:0] odd_start,
   input wire [AW-1:0] even_start,
   input wire [AW-1:0] stride,
   input wire [AW-1:0] guard,
   input wire [AW-1:0] xlat_ctrl,
   input wire [31:0] data_in,
   output reg [AW-1:0] line_addr_r,
   output reg [31:0] data_out_r,
   output reg translate_r,
   output reg [19:0] table_base_r,
   output reg range_event_r,
   output reg guard_hit_r,
   output reg guard_mode_r
);
   reg [AW-1:0] line_addr_nxt;
   wire [4:0] lim_shift;
   wire [1:0] swap;
   assign lim_shift = {1'b0, xlat_ctrl[`VDC_LIM_HI:`VDC_LIM_LO]} + `VDC_LIM_BASE;
   assign swap = xlat_ctrl[`VDC_SWAP_HI:`VDC_SWAP_LO];

   function [31:0] reorder;
      input [31:0] d;
      input [1:0] mode;
      begin
         case (mode)
            `VDC_SWAP_HALF: reorder = {d[23:16], d[31:24], d[7:0], d[15:8]};
            `VDC_SWAP_FULL: reorder = {d[7:0], d[15:8], d[23:16], d[31:24]};
            default: reorder = d;
         endcase
      end
   endfunction

   always @* begin
      line_addr_nxt = line_addr_r;
      if (field_start)
         line_addr_nxt = field_odd ? odd_start : even_start; // [R1]
      else if (line_next)
         line_addr_nxt = line_addr_r + stride; // [R4]
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         line_addr_r <= `VDC_REG_RESET;
         data_out_r <= `VDC_REG_RESET;
         translate_r <= 1'b0;
         table_base_r <= 20'h00000;
         range_event_r <= 1'b0;
         guard_hit_r <= 1'b0;
         guard_mode_r <= 1'b0;
      end else begin
         line_addr_r <= line_addr_nxt;
         // Reserved swap code passes data unchanged
         data_out_r <= reorder(data_in, swap); // [R8]
         translate_r <= xlat_ctrl[`VDC_ME_BIT]; // [R6]
         table_base_r <= xlat_ctrl[`VDC_TBASE_HI:`VDC_TBASE_LO]; // [R5]
         // Boundary passed when a bit at or above the range size flips
         // A step in a start cycle is ignored, so it cannot cross a boundary
         range_event_r <= line_next && !field_start &&
            (((line_addr_r ^ line_addr_nxt) >> lim_shift) != {AW{1'b0}}); // [R7]
         guard_hit_r <= (line_next || field_start) &&
            ((line_addr_nxt & `VDC_GUARD_MASK) == (guard & `VDC_GUARD_MASK)); // [R15]
         guard_mode_r <= xlat_ctrl[`VDC_PV_BIT]; // [R11]
      end
   end
endmodule

// ---- rtl/vdc_video_dma.v ----
// Register set and addressing for two video DMA channels on the PCI clock.
// Assumes a PCI target front end decoding the base address and giving offset strobes.
`timescale 1ns/100ps
`include "vdc_consts.vh"
// Notes on behaviour
// [R1] Each channel holds odd and even field start addresses and picks by field parity.
// [R2] On channel 1 a negative stride makes the start the lower left pixel, lines descend.
// [R3] On channel 2 vertical flip makes the start the lower left pixel.
// [R4] Each next line address is the previous plus the signed 32-bit stride.
// [R5] Bits 31 to 12 of the control register hold the 4 KB aligned page table base.
// [R6] Bit 11 enables address translation; clear means unmapped addresses.
// [R7] Bits 7 to 4 size a range whose boundary crossing raises an event.
// [R8] Bits 1 and 0 select no swap, halfword swap, full reversal, or reserved.
// [R9] Channel 1 bits 27 to 16 count lines per field; further lines are discarded.
// [R10] Channel 1 bits 11 to 0 count pixels per line; further pixels are discarded.
// [R11] Guard address sits in bits 31 to 2 and bit 3 picks the violation handling.
// [R12] Channel 1 only writes into memory and never reads.
// [R13] Channel 2 bit 2 selects write to memory at 0 and read from memory at 1.
// [R14] The host reaches registers as a PCI target at base plus offset.
// [R15] Each transfer address is compared with the dword aligned guard address.
module vdc_video_dma #(
   parameter AW = 32,
   parameter CW = 12
) (
   input wire mclk,
   input wire reset_n,
   input wire reg_wr,
   input wire reg_rd,
   input wire [5:0] reg_offset,
   input wire [3:0] reg_be,
   input wire [31:0] reg_wdata,
   output reg [31:0] reg_rdata_r,
   output reg reg_ack_r,
   input wire ch1_field_start,
   input wire ch1_field_odd,
   input wire ch1_line_next,
   input wire ch1_pixel_valid,
   input wire ch1_line_end,
   input wire [31:0] ch1_data_in,
   output wire ch1_pixel_keep,
   output wire [AW-1:0] ch1_line_addr,
   output wire [31:0] ch1_data_out,
   output wire ch1_translate,
   output wire [19:0] ch1_page_base,
   output wire ch1_range_event,
   output wire ch1_guard_hit,
   output wire ch1_guard_mode,
   output wire ch1_mem_read,
   input wire ch2_field_start,
   input wire ch2_field_odd,
   input wire ch2_line_next,
   input wire ch2_vflip,
   input wire [31:0] ch2_data_in,
   output wire [AW-1:0] ch2_line_addr,
   output wire [31:0] ch2_data_out,
   output wire ch2_translate,
   output wire [19:0] ch2_page_base,
   output wire ch2_range_event,
   output wire ch2_guard_hit,
   output wire ch2_guard_mode,
   output wire ch2_mem_read
);
   reg [31:0] ch1_odd_field_start_r;
   reg [31:0] ch1_even_field_start_r;
   reg [31:0] ch1_guard_address_r;
   reg [31:0] ch1_line_stride_r;
   reg [31:0] ch1_translation_control_r;
   reg [31:0] ch1_field_size_r;
   reg [31:0] ch2_odd_field_start_r;
   reg [31:0] ch2_even_field_start_r;
   reg [31:0] ch2_guard_address_r;
   reg [31:0] ch2_line_stride_r;
   reg [31:0] ch2_translation_control_r;
   reg [CW-1:0] ch1_line_cnt_r;
   reg [CW-1:0] ch1_pix_cnt_r;
   reg ch1_line_full_r;
   reg ch1_pix_full_r;
   reg [31:0] rdata_nxt;
   wire [31:0] ch2_stride_eff;
   wire [CW-1:0] ch1_lines_per_field;
   wire [CW-1:0] ch1_pixels_per_line;

   // Byte-lane merge keeping only writable bits
   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0] be;
      input [31:0] mask;
      reg [31:0] lanes;
      begin
         lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
         merge = (old & ~lanes) | (wd & lanes);
      end
   endfunction

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ch1_odd_field_start_r <= `VDC_REG_RESET;
         ch1_even_field_start_r <= `VDC_REG_RESET;
         ch1_guard_address_r <= `VDC_REG_RESET;
         ch1_line_stride_r <= `VDC_REG_RESET;
         ch1_translation_control_r <= `VDC_REG_RESET;
         ch1_field_size_r <= `VDC_REG_RESET;
         ch2_odd_field_start_r <= `VDC_REG_RESET;
         ch2_even_field_start_r <= `VDC_REG_RESET;
         ch2_guard_address_r <= `VDC_REG_RESET;
         ch2_line_stride_r <= `VDC_REG_RESET;
         ch2_translation_control_r <= `VDC_REG_RESET;
      end else if (reg_wr) begin // [R14]
         case (reg_offset)
            `VDC_OFS_C1_ODD: ch1_odd_field_start_r <=
               merge(ch1_odd_field_start_r, reg_wdata, reg_be, 32'hffff_ffff);
            `VDC_OFS_C1_EVEN: ch1_even_field_start_r <=
               merge(ch1_even_field_start_r, reg_wdata, reg_be, 32'hffff_ffff);
            `VDC_OFS_C1_GUARD: ch1_guard_address_r <=
               merge(ch1_guard_address_r, reg_wdata, reg_be, `VDC_GUARD_MASK);
            `VDC_OFS_C1_STRIDE: ch1_line_stride_r <=
               merge(ch1_line_stride_r, reg_wdata, reg_be, 32'hffff_ffff);
            // Bit 2 stays zero: channel 1 has no read direction
            `VDC_OFS_C1_XLAT: ch1_translation_control_r <=
               merge(ch1_translation_control_r, reg_wdata, reg_be, `VDC_XLAT_MASK_C1); // [R12]
            `VDC_OFS_C1_SIZE: ch1_field_size_r <=
               merge(ch1_field_size_r, reg_wdata, reg_be, `VDC_SIZE_MASK);
            `VDC_OFS_C2_ODD: ch2_odd_field_start_r <=
               merge(ch2_odd_field_start_r, reg_wdata, reg_be, 32'hffff_ffff);
            `VDC_OFS_C2_EVEN: ch2_even_field_start_r <=
               merge(ch2_even_field_start_r, reg_wdata, reg_be, 32'hffff_ffff);
            `VDC_OFS_C2_GUARD: ch2_guard_address_r <=
               merge(ch2_guard_address_r, reg_wdata, reg_be, `VDC_GUARD_MASK);
            `VDC_OFS_C2_STRIDE: ch2_line_stride_r <=
               merge(ch2_line_stride_r, reg_wdata, reg_be, 32'hffff_ffff);
            `VDC_OFS_C2_XLAT: ch2_translation_control_r <=
               merge(ch2_translation_control_r, reg_wdata, reg_be, `VDC_XLAT_MASK_C2);
            default: ;
         endcase
      end
   end

   always @* begin
      case (reg_offset)
         `VDC_OFS_C1_ODD: rdata_nxt = ch1_odd_field_start_r;
         `VDC_OFS_C1_EVEN: rdata_nxt = ch1_even_field_start_r;
         `VDC_OFS_C1_GUARD: rdata_nxt = ch1_guard_address_r;
         `VDC_OFS_C1_STRIDE: rdata_nxt = ch1_line_stride_r;
         `VDC_OFS_C1_XLAT: rdata_nxt = ch1_translation_control_r;
         `VDC_OFS_C1_SIZE: rdata_nxt = ch1_field_size_r;
         `VDC_OFS_C2_ODD: rdata_nxt = ch2_odd_field_start_r;
         `VDC_OFS_C2_EVEN: rdata_nxt = ch2_even_field_start_r;
         `VDC_OFS_C2_GUARD: rdata_nxt = ch2_guard_address_r;
         `VDC_OFS_C2_STRIDE: rdata_nxt = ch2_line_stride_r;
         `VDC_OFS_C2_XLAT: rdata_nxt = ch2_translation_control_r;
         default: rdata_nxt = `VDC_REG_RESET;
      endcase
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata_r <= `VDC_REG_RESET;
         reg_ack_r <= 1'b0;
      end else begin
         reg_ack_r <= reg_wr | reg_rd;
         if (reg_rd)
            reg_rdata_r <= rdata_nxt;
      end
   end

   // Cut-off counters at the scaler input for channel 1
   assign ch1_lines_per_field = ch1_field_size_r[`VDC_LINES_HI:`VDC_LINES_LO];
   assign ch1_pixels_per_line = ch1_field_size_r[`VDC_PIX_HI:`VDC_PIX_LO];
   assign ch1_pixel_keep = ch1_pixel_valid && !ch1_line_full_r && !ch1_pix_full_r; // [R9] [R10]

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ch1_line_cnt_r <= {CW{1'b0}};
         ch1_pix_cnt_r <= {CW{1'b0}};
         ch1_line_full_r <= 1'b0;
         ch1_pix_full_r <= 1'b0;
      end else begin
         if (ch1_field_start) begin
            ch1_line_cnt_r <= {CW{1'b0}};
            ch1_line_full_r <= (ch1_lines_per_field == {CW{1'b0}});
         end else if (ch1_line_end && !ch1_line_full_r) begin
            ch1_line_cnt_r <= ch1_line_cnt_r + 1'b1;
            ch1_line_full_r <= (ch1_line_cnt_r + 1'b1 == ch1_lines_per_field); // [R9]
         end
         if (ch1_field_start || ch1_line_end) begin
            ch1_pix_cnt_r <= {CW{1'b0}};
            ch1_pix_full_r <= (ch1_pixels_per_line == {CW{1'b0}});
         end else if (ch1_pixel_keep) begin
            ch1_pix_cnt_r <= ch1_pix_cnt_r + 1'b1;
            ch1_pix_full_r <= (ch1_pix_cnt_r + 1'b1 == ch1_pixels_per_line); // [R10]
         end
      end
   end

   // Vertical flip negates the stored stride so lines descend; start is then the lower left pixel
   assign ch2_stride_eff = ch2_vflip ? (~ch2_line_stride_r + 32'h0000_0001)
                                     : ch2_line_stride_r; // [R3]
   assign ch1_mem_read = 1'b0; // [R12]
   assign ch2_mem_read = ch2_translation_control_r[`VDC_DIR_BIT]; // [R13]

   vdc_chan_addr #(.AW(AW)) u_ch1 (
      .mclk(mclk),
      .reset_n(reset_n),
      .field_start(ch1_field_start),
      .field_odd(ch1_field_odd),
      .line_next(ch1_line_next),
      .odd_start(ch1_odd_field_start_r),
      .even_start(ch1_even_field_start_r),
      .stride(ch1_line_stride_r), // [R2]
      .guard(ch1_guard_address_r),
      .xlat_ctrl(ch1_translation_control_r),
      .data_in(ch1_data_in),
      .line_addr_r(ch1_line_addr),
      .data_out_r(ch1_data_out),
      .translate_r(ch1_translate),
      .table_base_r(ch1_page_base),
      .range_event_r(ch1_range_event),
      .guard_hit_r(ch1_guard_hit),
      .guard_mode_r(ch1_guard_mode)
   );

   vdc_chan_addr #(.AW(AW)) u_ch2 (
      .mclk(mclk),
      .reset_n(reset_n),
      .field_start(ch2_field_start),
      .field_odd(ch2_field_odd),
      .line_next(ch2_line_next),
      .odd_start(ch2_odd_field_start_r),
      .even_start(ch2_even_field_start_r),
      .stride(ch2_stride_eff),
      .guard(ch2_guard_address_r),
      .xlat_ctrl(ch2_translation_control_r),
      .data_in(ch2_data_in),
      .line_addr_r(ch2_line_addr),
      .data_out_r(ch2_data_out),
      .translate_r(ch2_translate),
      .table_base_r(ch2_page_base),
      .range_event_r(ch2_range_event),
      .guard_hit_r(ch2_guard_hit),
      .guard_mode_r(ch2_guard_mode)
   );
endmodule

// ---- verif/vdc_video_dma_assertions.sv ----
// Port checker for the two-channel video DMA block.
// Assumes one clock domain, mclk, with reset_n async and active low.
`timescale 1ns/100ps
module vdc_chk #(
   parameter AW = 32
) (
   input wire mclk,
   input wire reset_n,
   input wire reg_wr,
   input wire reg_rd,
   input wire reg_ack_r,
   input wire ch1_field_start,
   input wire ch1_line_next,
   input wire [AW-1:0] ch1_line_addr,
   input wire [31:0] ch1_data_in,
   input wire [31:0] ch1_data_out,
   input wire ch1_range_event,
   input wire ch1_guard_hit,
   input wire ch1_mem_read,
   input wire ch2_field_start,
   input wire ch2_line_next,
   input wire [AW-1:0] ch2_line_addr
);
   // Byte parity survives any reordering, so it holds for every swap mode
   function automatic [7:0] bx(input [31:0] d);
      bx = d[7:0] ^ d[15:8] ^ d[23:16] ^ d[31:24];
   endfunction
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   property p_ack; (reg_wr || reg_rd) |=> reg_ack_r; endproperty
   property p_noack; !(reg_wr || reg_rd) |=> !reg_ack_r; endproperty
   property p_wonly; !ch1_mem_read; endproperty
   property p_hold1; !(ch1_field_start || ch1_line_next) |=> $stable(ch1_line_addr); endproperty
   property p_hold2; !(ch2_field_start || ch2_line_next) |=> $stable(ch2_line_addr); endproperty
   property p_swap; $past(reset_n) |-> bx(ch1_data_out) == bx($past(ch1_data_in)); endproperty
   property p_rng; ch1_range_event |-> $past(ch1_line_next && !ch1_field_start); endproperty
   property p_hit; ch1_guard_hit |-> $past(ch1_field_start || ch1_line_next); endproperty
   a_ack: assert property (p_ack) else $error("no ack after access");
   a_noack: assert property (p_noack) else $error("ack without access");
   a_wonly: assert property (p_wonly) else $error("channel 1 reads memory");
   a_hold1: assert property (p_hold1) else $error("ch1 address moved idle");
   a_hold2: assert property (p_hold2) else $error("ch2 address moved idle");
   a_swap: assert property (p_swap) else $error("swap lost bytes");
   a_rng: assert property (p_rng) else $error("range event without step");
   a_hit: assert property (p_hit) else $error("guard hit without step");
   c_rng: cover property (ch1_range_event);
   c_hit: cover property (ch1_guard_hit);
   c_rd: cover property (reg_rd ##1 reg_ack_r);
endmodule
bind vdc_video_dma vdc_chk #(.AW(AW)) chk_u (.mclk(mclk), .reset_n(reset_n), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_ack_r(reg_ack_r), .ch1_field_start(ch1_field_start),
   .ch1_line_next(ch1_line_next), .ch1_line_addr(ch1_line_addr), .ch1_data_in(ch1_data_in),
   .ch1_data_out(ch1_data_out), .ch1_range_event(ch1_range_event),
   .ch1_guard_hit(ch1_guard_hit), .ch1_mem_read(ch1_mem_read),
   .ch2_field_start(ch2_field_start), .ch2_line_next(ch2_line_next),
   .ch2_line_addr(ch2_line_addr));

// ---- verif/vdc_scaler_model.sv ----
// Stand-in for the scaler input side: one line of four pixels per go pulse.
// Assumes go is a one-cycle pulse and lines do not overlap.
`timescale 1ns/100ps
module vdc_scaler_model (
   input wire mclk,
   input wire reset_n,
   input wire go,
   output reg pixel_valid,
   output reg line_end
);
   reg [2:0] n_r;
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         n_r <= 3'h0;
         pixel_valid <= 1'b0;
         line_end <= 1'b0;
      end else begin
         pixel_valid <= n_r != 3'h0;
         // Line end trails the last pixel so it never races the pixel count
         line_end <= n_r == 3'h0 && pixel_valid;
         n_r <= go ? 3'h4 : (n_r != 3'h0 ? n_r - 3'h1 : 3'h0);
      end
   end
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the two-channel video DMA addressing block.
// Assumes the scaler stand-in and the bound checker are compiled beside it.
`timescale 1ns/100ps
module tb;
   reg mclk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, go = 0;
   reg [5:0] reg_offset = 0;
   reg [3:0] reg_be = 0;
   reg [31:0] reg_wdata = 0, ch1_data_in = 0, ch2_data_in = 0;
   reg ch1_field_start = 0, ch1_field_odd = 0, ch1_line_next = 0;
   reg ch2_field_start = 0, ch2_field_odd = 0, ch2_line_next = 0, ch2_vflip = 0;
   wire [31:0] reg_rdata_r, ch1_line_addr, ch1_data_out, ch2_line_addr, ch2_data_out;
   wire [19:0] ch1_page_base, ch2_page_base;
   wire reg_ack_r, ch1_pixel_valid, ch1_line_end, ch1_pixel_keep, ch1_translate;
   wire ch1_range_event, ch1_guard_hit, ch1_guard_mode, ch1_mem_read, ch2_translate;
   wire ch2_range_event, ch2_guard_hit, ch2_guard_mode, ch2_mem_read;
   integer fails = 0, checks_done = 0, i, k;
   always #25 mclk = ~mclk;
   vdc_video_dma dut_u (.mclk, .reset_n, .reg_wr, .reg_rd, .reg_offset, .reg_be, .reg_wdata,
      .reg_rdata_r, .reg_ack_r, .ch1_field_start, .ch1_field_odd, .ch1_line_next,
      .ch1_pixel_valid, .ch1_line_end, .ch1_data_in, .ch1_pixel_keep, .ch1_line_addr,
      .ch1_data_out, .ch1_translate, .ch1_page_base, .ch1_range_event, .ch1_guard_hit,
      .ch1_guard_mode, .ch1_mem_read, .ch2_field_start, .ch2_field_odd, .ch2_line_next,
      .ch2_vflip, .ch2_data_in, .ch2_line_addr, .ch2_data_out, .ch2_translate,
      .ch2_page_base, .ch2_range_event, .ch2_guard_hit, .ch2_guard_mode, .ch2_mem_read);
   vdc_scaler_model scl_u (.mclk, .reset_n, .go, .pixel_valid(ch1_pixel_valid),
      .line_end(ch1_line_end));
   task chk(input string nm, input [31:0] got, input [31:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task wr(input [5:0] o, input [31:0] d, input [3:0] be);
      @(posedge mclk) #1;
      {reg_wr, reg_offset, reg_wdata, reg_be} = {1'b1, o, d, be};
      @(posedge mclk) #1;
      reg_wr = 0;
      chk("wr ack", reg_ack_r, 32'h1);
   endtask
   task rd(input [5:0] o, input [31:0] e, input string nm);
      @(posedge mclk) #1;
      reg_rd = 1;
      reg_offset = o;
      @(posedge mclk) #1;
      reg_rd = 0;
      chk(nm, reg_rdata_r, e);
      chk("rd ack", reg_ack_r, 32'h1);
   endtask
   task step(input [4:0] s);
      @(posedge mclk) #1;
      {go, ch1_field_start, ch1_line_next, ch2_field_start, ch2_line_next} = s;
      @(posedge mclk) #1;
      {go, ch1_field_start, ch1_line_next, ch2_field_start, ch2_line_next} = 5'h0;
   endtask
   function [31:0] msk(input [5:0] o);
      case (o)
         6'h08, 6'h20: msk = 32'hffff_fffc;
         6'h10: msk = 32'hffff_f8fb;
         6'h14: msk = 32'h0fff_0fff;
         6'h28: msk = 32'hffff_f8ff;
         default: msk = 32'hffff_ffff;
      endcase
   endfunction
   task s_regs;
      for (i = 0; i < 11; i = i + 1) begin
         rd(6'(i * 4), 32'h0, "reset value");
         wr(6'(i * 4), 32'hffff_ffff, 4'hf);
         rd(6'(i * 4), msk(6'(i * 4)), "readback");
      end
      wr(6'h2c, 32'hffff_ffff, 4'hf);
      rd(6'h2c, 32'h0, "unmapped");
      wr(6'h0c, 32'h0, 4'h1);
      rd(6'h0c, 32'hffff_ff00, "byte lane");
   endtask
   task s_addr;
      wr(6'h00, 32'h1000, 4'hf);
      wr(6'h04, 32'h2000, 4'hf);
      ch1_field_odd = 1;
      step(5'h08);
      chk("c1 odd", ch1_line_addr, 32'h1000);
      step(5'h04);
      chk("c1 down", ch1_line_addr, 32'h0f00);
      step(5'h0c);
      chk("c1 start wins", ch1_line_addr, 32'h1000);
      ch1_field_odd = 0;
      step(5'h08);
      chk("c1 even", ch1_line_addr, 32'h2000);
      wr(6'h18, 32'h8000, 4'hf);
      wr(6'h24, 32'h40, 4'hf);
      ch2_field_odd = 1;
      ch2_vflip = 1;
      step(5'h02);
      chk("c2 odd", ch2_line_addr, 32'h8000);
      step(5'h01);
      chk("c2 flip", ch2_line_addr, 32'h7fc0);
      ch2_vflip = 0;
      step(5'h01);
      chk("c2 step", ch2_line_addr, 32'h8000);
      wr(6'h28, 32'h4, 4'hf);
      chk("c2 read", ch2_mem_read, 32'h1);
      chk("c1 read", ch1_mem_read, 32'h0);
      wr(6'h28, 32'h0, 4'hf);
      chk("c2 write", ch2_mem_read, 32'h0);
   endtask
   task s_ctrl;
      wr(6'h10, 32'habcd_e808, 4'hf);
      @(posedge mclk) #1;
      chk("xlat on", ch1_translate, 32'h1);
      chk("table base", ch1_page_base, 32'habcde);
      chk("guard mode", ch1_guard_mode, 32'h1);
      wr(6'h10, 32'h0, 4'hf);
      @(posedge mclk) #1;
      chk("xlat off", ch1_translate, 32'h0);
      wr(6'h28, 32'habcd_e80a, 4'hf);
      ch2_data_in = 32'h1122_3344;
      @(posedge mclk) #1;
      chk("c2 xlat on", ch2_translate, 32'h1);
      chk("c2 table base", ch2_page_base, 32'habcde);
      chk("c2 guard mode", ch2_guard_mode, 32'h1);
      chk("c2 swap", ch2_data_out, 32'h4433_2211);
      for (i = 0; i < 4; i = i + 1) begin
         wr(6'h10, 32'(i), 4'hf);
         ch1_data_in = 32'h1122_3344;
         @(posedge mclk) #1;
         chk("swap", ch1_data_out, i == 1 ? 32'h2211_4433 : i == 2 ? 32'h4433_2211 :
            32'h1122_3344);
      end
   endtask
   task s_range;
      wr(6'h10, 32'h0, 4'hf);
      wr(6'h00, 32'h3f0, 4'hf);
      wr(6'h0c, 32'h10, 4'hf);
      wr(6'h08, 32'h400, 4'hf);
      ch1_field_odd = 1;
      step(5'h08);
      chk("no event", ch1_range_event, 32'h0);
      step(5'h04);
      chk("event", ch1_range_event, 32'h1);
      chk("guard hit", ch1_guard_hit, 32'h1);
      step(5'h04);
      chk("guard past", ch1_guard_hit, 32'h0);
      step(5'h0c);
      chk("start no event", ch1_range_event, 32'h0);
      wr(6'h10, 32'h10, 4'hf);
      step(5'h08);
      step(5'h04);
      chk("2k no event", ch1_range_event, 32'h0);
      wr(6'h18, 32'h3c0, 4'hf);
      wr(6'h20, 32'h400, 4'hf);
      step(5'h02);
      chk("c2 no event", ch2_range_event, 32'h0);
      step(5'h01);
      chk("c2 event", ch2_range_event, 32'h1);
      chk("c2 guard hit", ch2_guard_hit, 32'h1);
   endtask
   task cut(input [31:0] e, input string nm);
      k = 0;
      step(5'h10);
      repeat (8) @(negedge mclk) if (ch1_pixel_valid === 1 && ch1_pixel_keep === 1) k = k + 1;
      chk(nm, 32'(k), e);
   endtask
   task s_cut;
      wr(6'h14, 32'h0001_0002, 4'hf);
      step(5'h08);
      cut(32'h2, "pixels kept");
      cut(32'h0, "line cut");
      step(5'h08);
      cut(32'h2, "new field");
   endtask
   task end_sim;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      #1 reset_n = 1;
      s_regs;
      s_addr;
      s_ctrl;
      s_range;
      s_cut;
      end_sim;
   end
   // Whole run is well under a thousand cycles
   initial begin
      #200000;
      fails = fails + 1;
      end_sim;
   end
endmodule
